// >>> src/uct_pkg.sv
package uct_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CNT_UPPER  = 8'h00;  // count_upper_byte
  localparam logic [7:0] ADDR_CNT_LOWER  = 8'h04;  // count_lower_byte
  localparam logic [7:0] ADDR_AUX_CTRL   = 8'h08;  // auxiliary_control_reg
  localparam logic [7:0] ADDR_CSEL_A     = 8'h0C;  // chan_a_clock_select
  localparam logic [7:0] ADDR_CSEL_B     = 8'h10;  // chan_b_clock_select
  localparam logic [7:0] ADDR_CMD_A      = 8'h14;  // chan_a_command_reg
  localparam logic [7:0] ADDR_CMD_B      = 8'h18;  // chan_b_command_reg
  localparam logic [7:0] ADDR_INT_STAT   = 8'h1C;  // interrupt_status_reg
  localparam logic [7:0] ADDR_INT_MASK   = 8'h20;  // interrupt_mask_reg
  localparam logic [7:0] ADDR_OUT_CFG    = 8'h24;  // pin three routing
  localparam logic [7:0] ADDR_START      = 8'h28;  // start counter trigger
  localparam logic [7:0] ADDR_STOP       = 8'h2C;  // stop counter trigger
  localparam logic [7:0] ADDR_EXT_SEL    = 8'h30;  // ext pin per path
  localparam logic [7:0] ADDR_CLK_STAT   = 8'h34;  // live extend bits and count

  // ---------------------------------------------------------------
  // fields and codes
  // ---------------------------------------------------------------
  localparam int          ACR_SET_BIT    = 7;
  localparam int          ISR_READY_BIT  = 3;
  localparam logic [7:0]  CMD_RX_EXT_SET = 8'h08;
  localparam logic [7:0]  CMD_RX_EXT_CLR = 8'h09;
  localparam logic [7:0]  CMD_TX_EXT_SET = 8'h0A;
  localparam logic [7:0]  CMD_TX_EXT_CLR = 8'h0B;
  localparam logic [3:0]  CS_TIMER       = 4'hD;
  localparam logic [3:0]  CS_EXT16       = 4'hE;
  localparam logic [3:0]  CS_EXT1        = 4'hF;
  localparam logic [15:0] CNT_ZERO       = 16'h0000;
  localparam logic [15:0] CNT_ONE        = 16'h0001;
  localparam logic [3:0]  PRESCALE_LAST  = 4'hF;   // divide by 16
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  // source select, auxiliary bits 6:4
  typedef enum logic [2:0] {
    SRC_CNT_PIN2  = 3'b000,
    SRC_CNT_TXA   = 3'b001,
    SRC_CNT_TXB   = 3'b010,
    SRC_CNT_OSC16 = 3'b011,
    SRC_TMR_PIN2  = 3'b100,
    SRC_TMR_PIN16 = 3'b101,
    SRC_TMR_OSC   = 3'b110,
    SRC_TMR_OSC16 = 3'b111
  } uct_src_type;

  // counter/timer run state
  typedef enum logic [0:0] {
    CT_IDLE = 1'b0,
    CT_RUN  = 1'b1
  } uct_state_type;

  // generator rate table: 16x tick period in oscillator cycles, as
  // {set bit, extend bit, code}; 13 codes x 4 columns at 3.6864 MHz
  function automatic logic [15:0] uct_rate_div(input logic [5:0] key);
    logic [15:0] d;
    d = 16'h0000;
    unique case (key[3:0])
      4'h0: d = (key[5] ^ key[4]) ? 16'h0C00 : 16'h1200;
      4'h1: d = 16'h082E;
      4'h2: d = 16'h06B1;
      4'h3: d = (key[5] ^ key[4]) ? 16'h0600 : 16'h0480;
      4'h4: d = key[4] ? 16'h0040 : 16'h0300;
      4'h5: d = key[4] ? 16'h0010 : 16'h0180;
      4'h6: d = key[4] ? 16'h0008 : 16'h00C0;
      4'h7: d = key[4] ? 16'h0004 : (key[5] ? 16'h0073 : 16'h00DB);
      4'h8: d = key[4] ? 16'h0002 : 16'h0060;
      4'h9: d = 16'h0030;
      4'hA: d = (key[5] ^ key[4]) ? 16'h0080 : 16'h0020;
      4'hB: d = 16'h0018;
      4'hC: d = (key[5] ^ key[4]) ? 16'h000C : 16'h0006;
      default: d = 16'h0000;
    endcase
    return d;
  endfunction : uct_rate_div

endpackage : uct_pkg

// >>> src/uct_timing.sv
`timescale 1ns/1ps
`default_nettype none

module uct_timing (
  // oscillator clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // axi4-lite write address / data / response
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // external input pins two to five
  input  wire logic [3:0]  inputPins,
  // channel transmit 1x clock strobes for counter mode
  input  wire logic        chanATransmitClock,
  input  wire logic        chanBTransmitClock,
  // selected clock strobes: a tx, a rx, b tx, b rx
  output var  logic [3:0]  pathClk16,
  output var  logic [3:0]  pathClk1,
  // pin three and interrupt request
  output var  logic        outputPinThree,
  output var  logic        irq
);
  import uct_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]    countUpper, countLower, auxCtrl, intMask;
  logic [7:0]    chanAClockSelect, chanBClockSelect;
  logic          pinThreeIsTimer;
  logic [7:0]    extSel;          // 2-bit pin index per path
  logic [3:0]    extendBit;       // a tx, a rx, b tx, b rx
  logic          readyFlag;
  uct_state_type ctState;
  logic [15:0]   ctCount;
  logic          ctWave;
  logic [3:0]    preScale;
  logic [3:0]    pinMeta, pinSync, pinLast;
  logic          txALast, txBLast;

  // ---------------------------------------------------------------
  // axi4-lite slave: one write, one read at a time
  // ---------------------------------------------------------------
  logic        awHeld, wHeld;
  logic [7:0]  awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  wire         wrFire = awHeld & wHeld & ~s_axi_bvalid;
  wire         rdFire = s_axi_arvalid & s_axi_arready;
  wire         wrLane = wStrb[0];
  wire [7:0]   wByte  = wData[7:0];

  wire wrUpper = wrFire & wrLane & (awAddr == ADDR_CNT_UPPER);
  wire wrLower = wrFire & wrLane & (awAddr == ADDR_CNT_LOWER);
  wire wrAux   = wrFire & wrLane & (awAddr == ADDR_AUX_CTRL);
  wire wrCselA = wrFire & wrLane & (awAddr == ADDR_CSEL_A);
  wire wrCselB = wrFire & wrLane & (awAddr == ADDR_CSEL_B);
  wire wrCmdA  = wrFire & wrLane & (awAddr == ADDR_CMD_A);
  wire wrCmdB  = wrFire & wrLane & (awAddr == ADDR_CMD_B);
  wire wrMask  = wrFire & wrLane & (awAddr == ADDR_INT_MASK);
  wire wrOut   = wrFire & wrLane & (awAddr == ADDR_OUT_CFG);
  wire wrExt   = wrFire & wrLane & (awAddr == ADDR_EXT_SEL);
  // address-triggered: any write, data ignored
  wire startCmd = wrFire & (awAddr == ADDR_START);
  wire stopCmd  = wrFire & (awAddr == ADDR_STOP);
  wire wrMapped = wrUpper | wrLower | wrAux | wrCselA | wrCselB |
                  wrCmdA | wrCmdB | wrMask | wrOut | wrExt |
                  startCmd | stopCmd | (awAddr == ADDR_INT_STAT) |
                  (awAddr == ADDR_CLK_STAT);

  // write channel capture and response
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= BYTE_ZERO;
      wData  <= '0;
      wStrb  <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld <= 1'b0;
        wHeld  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= ~awHeld & ~(s_axi_awvalid & s_axi_awready) &
                       ~s_axi_bvalid;
      s_axi_wready  <= ~wHeld & ~(s_axi_wvalid & s_axi_wready) &
                       ~s_axi_bvalid;
    end
  end

  // read decode
  wire [7:0] rdAddr = s_axi_araddr;
  logic [31:0] rdValue;
  logic        rdOk;
  always_comb begin
    rdOk    = 1'b1;
    rdValue = '0;
    unique case (rdAddr)
      ADDR_CNT_UPPER: rdValue[7:0] = countUpper;
      ADDR_CNT_LOWER: rdValue[7:0] = countLower;
      ADDR_AUX_CTRL:  rdValue[7:0] = auxCtrl;
      ADDR_CSEL_A:    rdValue[7:0] = chanAClockSelect;
      ADDR_CSEL_B:    rdValue[7:0] = chanBClockSelect;
      ADDR_INT_STAT:  rdValue[ISR_READY_BIT] = readyFlag;
      ADDR_INT_MASK:  rdValue[7:0] = intMask;
      ADDR_OUT_CFG:   rdValue[0] = pinThreeIsTimer;
      ADDR_EXT_SEL:   rdValue[7:0] = extSel;
      ADDR_CLK_STAT:  rdValue[19:0] = {extendBit, ctCount};
      ADDR_CMD_A, ADDR_CMD_B, ADDR_START, ADDR_STOP: rdValue = '0;
      default:        rdOk = 1'b0;
    endcase
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~rdFire;
      if (rdFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdValue;
        s_axi_rresp  <= rdOk ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      countUpper <= BYTE_ZERO;
      countLower <= BYTE_ZERO;
      auxCtrl    <= BYTE_ZERO;
      intMask    <= BYTE_ZERO;
      chanAClockSelect <= BYTE_ZERO;
      chanBClockSelect <= BYTE_ZERO;
      pinThreeIsTimer  <= 1'b0;
      extSel     <= BYTE_ZERO;
    end else begin
      if (wrUpper) countUpper <= wByte;
      if (wrLower) countLower <= wByte;
      if (wrAux)   auxCtrl    <= wByte;
      if (wrMask)  intMask    <= wByte;
      if (wrCselA) chanAClockSelect <= wByte;
      if (wrCselB) chanBClockSelect <= wByte;
      if (wrOut)   pinThreeIsTimer  <= wByte[0];
      if (wrExt)   extSel     <= wByte;
    end
  end

  // extend bits change only by command codes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      extendBit <= '0;
    end else begin
      if (wrCmdA & (wByte == CMD_TX_EXT_SET)) extendBit[0] <= 1'b1;
      if (wrCmdA & (wByte == CMD_TX_EXT_CLR)) extendBit[0] <= 1'b0;
      if (wrCmdA & (wByte == CMD_RX_EXT_SET)) extendBit[1] <= 1'b1;
      if (wrCmdA & (wByte == CMD_RX_EXT_CLR)) extendBit[1] <= 1'b0;
      if (wrCmdB & (wByte == CMD_TX_EXT_SET)) extendBit[2] <= 1'b1;
      if (wrCmdB & (wByte == CMD_TX_EXT_CLR)) extendBit[2] <= 1'b0;
      if (wrCmdB & (wByte == CMD_RX_EXT_SET)) extendBit[3] <= 1'b1;
      if (wrCmdB & (wByte == CMD_RX_EXT_CLR)) extendBit[3] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // input synchronisers and edge strobes
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinMeta <= '0;
      pinSync <= '0;
      pinLast <= '0;
      txALast <= 1'b0;
      txBLast <= 1'b0;
    end else begin
      pinMeta <= inputPins;
      pinSync <= pinMeta;
      pinLast <= pinSync;
      txALast <= chanATransmitClock;
      txBLast <= chanBTransmitClock;
    end
  end
  wire [3:0] pinRise = pinSync & ~pinLast;
  wire       txARise = chanATransmitClock & ~txALast;
  wire       txBRise = chanBTransmitClock & ~txBLast;

  // ---------------------------------------------------------------
  // counter/timer source
  // ---------------------------------------------------------------
  uct_src_type srcSel;
  assign srcSel = uct_src_type'(auxCtrl[6:4]);
  wire timerMode = auxCtrl[6];
  wire preTick   = (preScale == PRESCALE_LAST);
  logic srcTick;
  always_comb begin
    unique case (srcSel)
      SRC_CNT_PIN2:  srcTick = pinRise[0];
      SRC_CNT_TXA:   srcTick = txARise;
      SRC_CNT_TXB:   srcTick = txBRise;
      SRC_CNT_OSC16: srcTick = preTick;
      SRC_TMR_PIN2:  srcTick = pinRise[0];
      SRC_TMR_PIN16: srcTick = preTick;
      SRC_TMR_OSC:   srcTick = 1'b1;
      SRC_TMR_OSC16: srcTick = preTick;
    endcase
  end
  // prescaler counts pin two edges in that mode, oscillator otherwise
  wire preStep = (srcSel == SRC_TMR_PIN16) ? pinRise[0] : 1'b1;

  // ---------------------------------------------------------------
  // counter/timer core
  // ---------------------------------------------------------------
  wire [15:0] countRegs = {countUpper, countLower};
  wire        running   = (ctState == CT_RUN);
  wire        halfDone  = timerMode & (ctCount <= CNT_ONE);
  wire        terminal  = ~timerMode & (ctCount == CNT_ONE);
  // a cycle ends as the wave falls, at the end of its high half
  wire        cycleDone = running & srcTick & halfDone & ctWave &
                          (countRegs != CNT_ZERO);
  wire        hitZero   = running & srcTick & terminal;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      preScale <= '0;
    end else if (preStep) begin
      preScale <= preScale + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctState <= CT_IDLE;
      ctCount <= CNT_ZERO;
      ctWave  <= 1'b1;
    end else if (startCmd) begin
      ctState <= CT_RUN;
      ctCount <= countRegs;
      ctWave  <= 1'b1;
    end else if (stopCmd & ~timerMode) begin
      ctState <= CT_IDLE;
      ctWave  <= 1'b1;
    end else if (running & srcTick) begin
      if (timerMode) begin
        if (countRegs == CNT_ZERO) begin
          ctWave <= ctWave;
        end else if (halfDone) begin
          ctCount <= countRegs;
          ctWave  <= ~ctWave;
        end else begin
          ctCount <= ctCount - CNT_ONE;
        end
      end else begin
        ctCount <= ctCount - CNT_ONE;                     // wraps
        if (terminal) ctWave <= 1'b0;
      end
    end
  end

  // ready flag: set wins over the stop clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      readyFlag <= 1'b0;
    end else if (cycleDone | hitZero) begin
      readyFlag <= 1'b1;
    end else if (stopCmd) begin
      readyFlag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // rate generator: one 16x divider per path
  // ---------------------------------------------------------------
  logic [15:0] rateCnt [4];
  logic [3:0]  rateTick;
  logic [3:0]  ctWaveLast;
  logic [3:0]  next_clk16, next_clk1;
  wire  [3:0]  ctRise = {4{ctWave & ~ctWaveLast[0]}};

  for (genvar p = 0; p < 4; p++) begin : g_path
    wire [7:0] csel = (p < 2) ? chanAClockSelect : chanBClockSelect;
    wire [3:0] code = p[0] ? csel[7:4] : csel[3:0];
    wire [1:0] pin  = extSel[2*p +: 2];
    wire [15:0] div = uct_rate_div({auxCtrl[ACR_SET_BIT],
                                    extendBit[p], code});
    // 16x generator tick, period from the table
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        rateCnt[p]  <= CNT_ZERO;
        rateTick[p] <= 1'b0;
      end else if (rateCnt[p] + CNT_ONE >= div) begin
        rateCnt[p]  <= CNT_ZERO;
        rateTick[p] <= 1'b1;
      end else begin
        rateCnt[p]  <= rateCnt[p] + CNT_ONE;
        rateTick[p] <= 1'b0;
      end
    end
    // source mux per path
    always_comb begin
      next_clk16[p] = 1'b0;
      next_clk1[p]  = 1'b0;
      if (code == CS_TIMER) begin
        next_clk16[p] = ctRise[p];
      end else if (code == CS_EXT16) begin
        next_clk16[p] = pinRise[pin];
      end else if (code == CS_EXT1) begin
        next_clk1[p]  = pinRise[pin];
      end else begin
        next_clk16[p] = rateTick[p];
      end
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctWaveLast     <= '1;
      pathClk16      <= '0;
      pathClk1       <= '0;
      outputPinThree <= 1'b1;
      irq            <= 1'b0;
    end else begin
      ctWaveLast     <= {4{ctWave}};
      pathClk16      <= next_clk16;
      pathClk1       <= next_clk1;
      outputPinThree <= pinThreeIsTimer ? ctWave : 1'b1;
      irq <= readyFlag & intMask[ISR_READY_BIT];
    end
  end

endmodule : uct_timing

`default_nettype wire

// >>> tb/uct_timing_properties.sv
`timescale 1ns/1ps
`default_nettype none
module uct_timing_properties
  import uct_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // clocks, pin and request
  input wire logic [3:0]  pathClk16,
  input wire logic [3:0]  pathClk1,
  input wire logic        outputPinThree,
  input wire logic        irq
);
  logic [7:0] wAddr;
  logic [7:0] wByte;
  logic       maskOn;
  logic       routeOn;
  logic       bSeen;
  wire        okAddr = (wAddr <= 8'h34) && (wAddr[1:0] == 2'b00);
  wire        bRise = s_axi_bvalid && !bSeen;
  // ------------------------------------------------------------
  // shadow of the mask and routing bits
  // ------------------------------------------------------------
  // applied one edge after the block, which matches its registered outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {wAddr, wByte, maskOn, routeOn, bSeen} <= '0;
    end else begin
      bSeen <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) wAddr <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wByte <= s_axi_wdata[7:0];
      if (bRise && wAddr == ADDR_INT_MASK) maskOn <= wByte[3];
      if (bRise && wAddr == ADDR_OUT_CFG) routeOn <= wByte[0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  AST_R_CLEAR: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid) else $error("read answer not withdrawn");
  AST_B_CLEAR: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("write answer not withdrawn");
  AST_BUSY: assert property ($rose(s_axi_bvalid) |->
    !s_axi_awready && !s_axi_wready) else $error("ready during answer");
  AST_WR_RESP: assert property ($rose(s_axi_bvalid) |->
    s_axi_bresp == (okAddr ? RESP_OKAY : RESP_SLVERR))
    else $error("wrong write response");
  AST_IRQ_MASK: assert property (!maskOn |-> !irq)
    else $error("request while masked");
  AST_PIN_IDLE: assert property (!routeOn |-> outputPinThree)
    else $error("pin low while not routed");
  AST_P16_PULSE: assert property ((pathClk16 & $past(pathClk16)) == '0)
    else $error("16x strobe longer than a cycle");
  AST_P1_PULSE: assert property ((pathClk1 & $past(pathClk1)) == '0)
    else $error("1x strobe longer than a cycle");
  cover property ($rose(irq));
  cover property ($fell(outputPinThree));
  cover property (|pathClk1);
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : uct_timing_properties
bind uct_timing uct_timing_properties uct_timing_properties_inst (
  .clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .pathClk16, .pathClk1,
  .outputPinThree, .irq
);
`default_nettype wire

// >>> tb/uct_chan_model.sv
`timescale 1ns/1ps
`default_nettype none
module uct_chan_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // pulse request
  input  wire logic       go,
  input  wire logic [7:0] count,
  // transmit 1x clocks
  output var  logic       txClkA,
  output var  logic       txClkB
);
  int left;
  // a strobe every other cycle, so each one is a distinct rising edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      left <= 0;
      txClkA <= 1'b0;
    end else if (go) begin
      left <= int'(count);
    end else if (left > 0 && !txClkA) begin
      txClkA <= 1'b1;
      left <= left - 1;
    end else begin
      txClkA <= 1'b0;
    end
  end
  assign txClkB = 1'b0; // channel b transmitter idles
endmodule : uct_chan_model
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import uct_pkg::*;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, r;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, pulseN;
  logic [3:0]  s_axi_wstrb, inputPins, pathClk16, pathClk1;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, outputPinThree;
  logic        irq, txA, txB, pulseGo, pinD;
  logic [33:0] expQ[$];
  int          nFail, nChecks, cyc, per, ones, rises, r0, n;
  wire  [4:0]  probe = {outputPinThree & ~pinD, pathClk16};
  uct_timing uct_timing_inst (.clk, .resetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .inputPins,
    .chanATransmitClock(txA), .chanBTransmitClock(txB), .pathClk16,
    .pathClk1, .outputPinThree, .irq);
  uct_chan_model uct_chan_model_inst (.clk, .resetn, .go(pulseGo),
    .count(pulseN), .txClkA(txA), .txClkB(txB));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [33:0] ok(input logic [7:0] b);
    return {RESP_OKAY, 24'h00_0000, b};
  endfunction : ok
  task automatic completeRun();
    $display("checks %0d mismatches %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : completeRun
  task automatic cmp(input string nm, input logic [33:0] e,
                     input logic [33:0] g);
    nChecks++;
    if (g !== e) begin
      nFail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic cmpNum(input string nm, input logic [15:0] e,
                        input logic [15:0] g);
    cmp(nm, {18'h0, e}, {18'h0, g});
  endtask : cmpNum
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : wr
  // the expectation is queued; the monitor compares it on the answer
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    expQ.push_back(e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : rd
  // skips one period first, since a settings change may cut the old one
  task automatic meas(input int b, output int p);
    repeat (2) do @(posedge clk); while (probe[b] !== 1'b1);
    p = 0;
    do begin
      @(posedge clk);
      p++;
    end while (probe[b] !== 1'b1);
  endtask : meas
  task automatic pulse(input logic [7:0] k);
    @(posedge clk);
    pulseN <= k;
    pulseGo <= 1'b1;
    @(posedge clk);
    pulseGo <= 1'b0;
    repeat (2 * k + 4) @(posedge clk);
  endtask : pulse
  // ------------------------------------------------------------
  // clock, watchdog, counters and read monitor
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    pinD <= outputPinThree;
    ones <= ones + int'(pathClk1[3]);
    rises <= rises + int'(probe[4]);
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      cmp("read", expQ.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (cyc == 20000) begin
      nFail++;
      completeRun();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, pulseGo} = '0;
    {s_axi_arvalid, s_axi_rready, resetn, pinD} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, inputPins, pulseN} = '0;
    s_axi_wstrb = 4'hF;
    {nFail, nChecks, cyc, ones, rises} = '0;
    seed = 32'h0000_1b39;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    r = rnd();
    rd(ADDR_CSEL_A, ok(8'h00));
    wr(ADDR_CSEL_B, r[7:0]);
    rd(ADDR_CSEL_B, ok(r[7:0]));
    rd(8'h3C, {RESP_SLVERR, 32'h0000_0000});
    wr(8'h40, 8'hFF);
    wr(ADDR_AUX_CTRL, 8'h80);
    wr(ADDR_CMD_A, CMD_TX_EXT_SET);
    wr(ADDR_CSEL_A, 8'h88);
    wr(ADDR_CSEL_B, 8'hBB);
    meas(0, per); cmpNum("a tx period", 2, 16'(per));
    meas(1, per); cmpNum("a rx period", 96, 16'(per));
    meas(2, per); cmpNum("b tx period", 24, 16'(per));
    wr(ADDR_CMD_A, CMD_RX_EXT_SET);
    meas(1, per); cmpNum("a rx period", 2, 16'(per));
    wr(ADDR_CMD_A, CMD_TX_EXT_CLR);
    meas(0, per); cmpNum("a tx period", 96, 16'(per));
    wr(ADDR_AUX_CTRL, 8'h60);
    wr(ADDR_CNT_LOWER, 8'h03);
    wr(ADDR_OUT_CFG, 8'h01);
    wr(ADDR_CSEL_A, 8'hDD);
    wr(ADDR_START, 8'h00);
    meas(4, per); cmpNum("wave period", 6, 16'(per));
    meas(0, per); cmpNum("timer clock", 6, 16'(per));
    wr(ADDR_CNT_LOWER, 8'h05);
    meas(4, per); cmpNum("wave period", 10, 16'(per));
    rd(ADDR_INT_STAT, ok(8'h08));
    wr(ADDR_INT_MASK, 8'h08);
    repeat (12) @(posedge clk);
    cmpNum("irq", 1, {15'h0, irq});
    wr(ADDR_STOP, 8'h00);
    meas(4, per); cmpNum("wave period", 10, 16'(per));
    wr(ADDR_CNT_LOWER, 8'h00);
    repeat (30) @(posedge clk);
    r0 = rises;
    repeat (40) @(posedge clk);
    cmpNum("frozen rises", 0, 16'(rises - r0));
    wr(ADDR_AUX_CTRL, 8'h10);
    wr(ADDR_CNT_LOWER, 8'h03);
    wr(ADDR_STOP, 8'h00);
    wr(ADDR_START, 8'h00);
    pulse(8'd2);
    cmpNum("pin", 1, {15'h0, outputPinThree});
    rd(ADDR_INT_STAT, ok(8'h00));
    pulse(8'd1);
    cmpNum("pin", 0, {15'h0, outputPinThree});
    rd(ADDR_INT_STAT, ok(8'h08));
    wr(ADDR_STOP, 8'h00);
    @(posedge clk);
    cmpNum("pin", 1, {15'h0, outputPinThree});
    rd(ADDR_INT_STAT, ok(8'h00));
    wr(ADDR_CSEL_B, 8'hF0);
    r0 = ones;
    n = 0;
    repeat (24) begin
      r = rnd();
      @(posedge clk);
      if (r[0] && !inputPins[0]) n++;
      inputPins <= r[3:0];
      repeat (3) @(posedge clk);
    end
    repeat (8) @(posedge clk);
    cmpNum("ext 1x strobes", 16'(n), 16'(ones - r0));
    completeRun();
  end
endmodule : tb_top
`default_nettype wire
